// ===== src/wcrc_checker.sv
// Write-CRC checker for burst-chop-four and full-burst write frames, one or two trees.
// Assumes pin beats arrive one per clock while valid is high, from outside the clock domain.
// What this block does
// - Chopped frame: data beats 0-3, ones in 4-7, CRC in beat 8, one in 9.
// - Start column bit one moves each lane's upper four tree positions onto its data beats.
// - Byte-wide, column bit one: mask lane bits 71..68 used only when enabled.
// - Sixteen-bit part has two identical independent trees of 72 inputs per byte group.
// - Lower tree takes mask lane bits 67..64 only when masking or inversion enabled.
// - Upper tree, column bit zero: bits 139..136 used only when enabled, else ones.
// - Upper tree, column bit one: bits 143..140 used only when enabled, else ones.
// - Byte-wide column-bit-zero CRC is a fixed XOR sum over 72 padded inputs.
// - Byte-wide column-bit-one CRC is the same sum over relocated upper-half bits.
// - Every checked frame is ten beats long, chopped or not.
// - Mismatch drives alert low at least six clocks and sets a sticky error bit.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module wcrc_checker
    import wcrc_pkg::*;
#(
    parameter int NUM_TREES = 1
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire wcrc_beat_t  pin_beat_i,
    input  wire wcrc_mode_t  mode_i,
    output logic             alert_out_o,
    output logic             alert_oe_n_o,
    output logic             irq_o,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int LANES = 9;

    // Ports from the pins pass two flops; the first stage is read by the second only.
    wcrc_beat_t beat_meta;
    wcrc_beat_t beat_s;
    wcrc_mode_t mode_meta;
    wcrc_mode_t mode_s;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            beat_meta <= '0;
            beat_s    <= '0;
            mode_meta <= '0;
            mode_s    <= '0;
        end else begin
            beat_meta <= pin_beat_i;
            beat_s    <= beat_meta;
            mode_meta <= mode_i;
            mode_s    <= mode_meta;
        end
    end

    logic [31:0] ctrl;
    logic [1:0]  status;
    logic [1:0]  irq_mask;
    logic [31:0] last_crc;

    // Frame capture: a fixed count of ten beats, whatever the burst type.
    logic [3:0]       beat_cnt;
    logic             frame_done;
    logic             frame_col;
    logic             frame_bc4;
    logic             mask_used;
    logic [LANES-1:0] beats [0:`WCRC_FRAME_BEATS-1] [0:1];
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            beat_cnt   <= 4'h0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (beat_s.valid) begin
                if (beat_cnt == 4'(`WCRC_FRAME_BEATS - 1)) begin
                    beat_cnt   <= 4'h0;
                    frame_done <= 1'b1;
                end else begin
                    beat_cnt <= beat_cnt + 4'h1;
                end
            end
        end
    end

    // Frame attributes are caught on the first beat; latching the mask choice there too
    // keeps a mode change part way through a frame from mixing two tree layouts.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            frame_col <= 1'b0;
            frame_bc4 <= 1'b0;
            mask_used <= 1'b0;
        end else if (beat_s.valid && beat_cnt == 4'h0) begin
            frame_col <= beat_s.start_column_bit;
            frame_bc4 <= beat_s.burst_chop_four;
            mask_used <= ctrl[`WCRC_CTRL_MASK_INV] | mode_s.write_byte_mask_en
                         | mode_s.bus_inversion_flag_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (beat_s.valid) begin
            beats[beat_cnt][0] <= {beat_s.mask_inversion_lane[0], beat_s.dq[7:0]};
            beats[beat_cnt][1] <= {beat_s.mask_inversion_lane[1], beat_s.dq[15:8]};
        end
    end

    // Serial form of the CRC-8 (x^8+x^2+x+1) matrix; unrolls to the fixed XOR sums.
    function automatic logic [7:0] crc_of(input logic [`WCRC_TREE_BITS-1:0] tree);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = `WCRC_TREE_BITS - 1; i >= 0; i--) begin
            fb = c[7] ^ tree[i];
            c  = {c[6:0], 1'b0} ^ (fb ? `WCRC_POLY : 8'h00);
        end
        return c;
    endfunction

    logic [1:0]  tree_err;
    logic [7:0]  tree_crc [0:1];
    logic [7:0]  tree_rx  [0:1];
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tree
            logic [`WCRC_TREE_BITS-1:0] tree;
            always_comb begin
                tree = '1;
                tree_rx[t] = 8'h00;
                for (int l = 0; l < LANES; l++) begin
                    for (int b = 0; b < 8; b++) begin
                        if (!frame_bc4) begin
                            tree[8*l+b] = beats[b][t][l];
                        end else if (b < 4) begin
                            // Upper half of the group when the column bit is one.
                            tree[8*l+b+(frame_col ? 4 : 0)] = beats[b][t][l];
                        end
                    end
                end
                // Mask lane tree inputs stay ones unless masking or inversion is on.
                if (!mask_used) begin
                    tree[71:64] = 8'hff;
                end
                for (int l = 0; l < 8; l++) begin
                    tree_rx[t][l] = beats[`WCRC_CRC_BEAT][t][l];
                end
            end
            assign tree_crc[t] = crc_of(tree);
            // The upper tree only exists on the sixteen-bit part.
            assign tree_err[t] = (t < NUM_TREES) && (tree_crc[t] != tree_rx[t]);
        end
    endgenerate

    // The trees are deep XOR sums; a register stage behind them keeps them off the
    // alert and status paths. The cost is one more edge of alert latency, well inside
    // what a controller has to allow for anyway.
    logic       check_q;
    logic [1:0] tree_err_q;
    logic [7:0] crc_calc_q [0:1];
    logic [7:0] crc_rx_q   [0:1];
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            check_q    <= 1'b0;
            tree_err_q <= 2'b00;
        end else begin
            check_q    <= frame_done;
            tree_err_q <= frame_done ? tree_err : 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            crc_calc_q[0] <= 8'h00;
            crc_calc_q[1] <= 8'h00;
            crc_rx_q[0]   <= 8'h00;
            crc_rx_q[1]   <= 8'h00;
        end else if (frame_done) begin
            crc_calc_q[0] <= tree_crc[0];
            crc_calc_q[1] <= tree_crc[1];
            crc_rx_q[0]   <= tree_rx[0];
            crc_rx_q[1]   <= tree_rx[1];
        end
    end

    logic crc_fail;
    assign crc_fail = check_q && ctrl[`WCRC_CTRL_CHECK_EN] && (tree_err_q != 2'b00);

    // Alert pulse: held low for the minimum width, retriggered by a later error.
    logic [2:0] alert_cnt;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            alert_cnt <= 3'h0;
        end else if (crc_fail) begin
            alert_cnt <= 3'(`WCRC_ALERT_CLOCKS);
        end else if (alert_cnt != 3'h0) begin
            alert_cnt <= alert_cnt - 3'h1;
        end
    end
    assign alert_out_o = 1'b0;

    // The pin enable comes straight from a flop so the pad sees no decode glitch.
    logic alert_drive;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            alert_drive <= 1'b0;
        end else begin
            alert_drive <= crc_fail || (alert_cnt > 3'h1);
        end
    end
    assign alert_oe_n_o = !alert_drive;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            last_crc <= 32'h0000_0000;
        end else if (check_q) begin
            last_crc <= {crc_rx_q[1], crc_rx_q[0], crc_calc_q[1], crc_calc_q[0]};
        end
    end

    // Register bus: address and data are taken independently and answered together.
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[11:0];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == `WCRC_OFF_CTRL || aw_addr == `WCRC_OFF_STATUS
                             || aw_addr == `WCRC_OFF_IRQ_MASK
                             || aw_addr == `WCRC_OFF_LAST_CRC) ? 2'b00 : 2'b10;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= `WCRC_CTRL_RESET;
        end else if (do_write && w_strb[0] && aw_addr == `WCRC_OFF_CTRL) begin
            ctrl <= {30'h0, w_data[1:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_mask <= 2'(`WCRC_MASK_RESET);
        end else if (do_write && w_strb[0] && aw_addr == `WCRC_OFF_IRQ_MASK) begin
            irq_mask <= w_data[1:0];
        end
    end

    // Sticky error bits: a new error in the clearing cycle wins over the clear.
    logic [1:0] status_clr;
    logic [1:0] status_set;
    assign status_clr = (do_write && w_strb[0] && aw_addr == `WCRC_OFF_STATUS)
                        ? w_data[1:0] : 2'b00;
    assign status_set = crc_fail ? tree_err_q : 2'b00;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status <= 2'b00;
        end else begin
            status <= (status & ~status_clr) | status_set;
        end
    end
    assign irq_o = |(status & irq_mask);

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Data is loaded only on acceptance, so it stands unchanged while the answer waits.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rresp <= 2'b00;
            unique case (s_axi_araddr[11:0])
                `WCRC_OFF_CTRL:     s_axi_rdata <= ctrl;
                `WCRC_OFF_STATUS:   s_axi_rdata <= {30'h0, status};
                `WCRC_OFF_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                `WCRC_OFF_LAST_CRC: s_axi_rdata <= last_crc;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
    end
endmodule

// ===== common/wcrc_consts.svh
// Constants for the write-CRC checker: register offsets, fields, frame and pulse timing.
// Assumes inclusion by bare name from the package; the design module sees the macros through it.
`ifndef WCRC_CONSTS_SVH
`define WCRC_CONSTS_SVH
`define WCRC_OFF_CTRL      12'h000
`define WCRC_OFF_STATUS    12'h004
`define WCRC_OFF_IRQ_MASK  12'h008
`define WCRC_OFF_LAST_CRC  12'h00c
`define WCRC_CTRL_MASK_INV 0
`define WCRC_CTRL_CHECK_EN 1
`define WCRC_CTRL_RESET    32'h0000_0002
`define WCRC_MASK_RESET    32'h0000_0000
`define WCRC_FRAME_BEATS   10
`define WCRC_CRC_BEAT      8
`define WCRC_TREE_BITS     72
`define WCRC_POLY          8'h07
`define WCRC_ALERT_CLOCKS  6
`endif

// ===== common/wcrc_pkg.sv
// Types shared by the write-CRC checker and its bench.
// Assumes the constants header sits on the include path.
package wcrc_pkg;
    `include "wcrc_consts.svh"

    typedef struct packed {
        logic        valid;
        logic        start_column_bit;
        logic        burst_chop_four;
        logic [1:0]  mask_inversion_lane;
        logic [15:0] dq;
    } wcrc_beat_t;

    typedef struct packed {
        logic        write_byte_mask_en;
        logic        bus_inversion_flag_en;
    } wcrc_mode_t;
endpackage

// ===== verification/wcrc_monitor.sv
// Concurrent checks on the alert pulse and the register bus of the write-CRC block.
// Assumes it is bound onto wcrc_checker and sees that module's ports only.
`timescale 1ns/1ns
module wcrc_monitor #(
    parameter int NUM_TREES = 1
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        alert_out_o,
    input wire logic        alert_oe_n_o,
    input wire logic        irq_o,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Counting the low run keeps the upper bound check cheap for the tools.
    logic [3:0] low_run;
    always_ff @(posedge clk_i) begin
        low_run <= (sys_rst_i || alert_oe_n_o) ? 4'h0 : low_run + 4'h1;
    end
    chk_alert_data_low: assert property (alert_out_o == 1'b0)
        else $error("alert data not low");
    chk_alert_min_width: assert property ($fell(alert_oe_n_o) |-> !alert_oe_n_o [*6])
        else $error("alert pulse too short");
    chk_alert_max_width: assert property (low_run <= 4'h6)
        else $error("alert pulse too long");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> alert_oe_n_o && !irq_o)
        else $error("outputs active after reset");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    cov_alert: cover property ($fell(alert_oe_n_o));
    cov_irq: cover property ($rose(irq_o));
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind wcrc_checker wcrc_monitor #(.NUM_TREES(NUM_TREES)) i_mon (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .alert_out_o(alert_out_o),
    .alert_oe_n_o(alert_oe_n_o), .irq_o(irq_o), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== verification/wcrc_ctrl_model.sv
// Controller model: drives chopped write frames with the CRC beat appended.
// Assumes the byte-wide form; the upper byte lanes carry only toggling filler.
`timescale 1ns/1ns
module wcrc_ctrl_model
    import wcrc_pkg::*;
(
    input  wire logic clk_i,
    output wcrc_beat_t pin_beat_o
);
    initial pin_beat_o = '0;
    function automatic logic [7:0] crc_of(input logic [71:0] t);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 71; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? `WCRC_POLY : 8'h00);
        end
        return c;
    endfunction
    task automatic send(input logic [31:0] d, input logic [3:0] m, input logic scb,
                        input logic men, input logic bad, output logic [7:0] crc);
        logic [71:0] t;
        t = '1;
        for (int b = 0; b < 4; b++) begin
            for (int l = 0; l < 8; l++) begin
                t[8 * l + b + 4 * scb] = d[8 * b + l];
            end
            if (men) t[64 + b + 4 * scb] = m[b];
        end
        crc = crc_of(t) ^ {7'h0, bad};
        for (int i = 0; i < `WCRC_FRAME_BEATS; i++) begin
            @(posedge clk_i);
            pin_beat_o.valid <= 1'b1;
            pin_beat_o.start_column_bit <= scb;
            pin_beat_o.burst_chop_four <= 1'b1;
            pin_beat_o.dq[15:8] <= ~pin_beat_o.dq[15:8];
            pin_beat_o.dq[7:0] <= (i < 4) ? d[8 * i +: 8] : (i == 8) ? crc : 8'hff;
            pin_beat_o.mask_inversion_lane <= {~pin_beat_o.mask_inversion_lane[1],
                                               (i < 4) ? m[i % 4] : 1'b1};
        end
    endtask
    task automatic idle();
        @(posedge clk_i);
        pin_beat_o.valid <= 1'b0;
        pin_beat_o.dq <= ~pin_beat_o.dq;
    endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the byte-wide write-CRC block.
// Assumes the controller model and the bound monitor are compiled alongside.
`timescale 1ns/1ns
module tb_top
    import wcrc_pkg::*;
;
    localparam logic [33:0] ALL = '1;
    localparam logic [33:0] LOW = 34'h3_00ff_00ff;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_o, alert_oe_n_o;
    logic [1:0]  rresp;
    logic [7:0]  c;
    wcrc_mode_t  mode = '0;
    wcrc_beat_t  beat;
    logic [15:0] seed = 16'h7873;
    logic [67:0] ent;
    logic [67:0] exp_q[$];
    int          bad_count = 0;
    int          n_checks = 0;
    int          n;
    always #2 clk_i = ~clk_i;
    wcrc_ctrl_model i_ctl (.clk_i(clk_i), .pin_beat_o(beat));
    wcrc_checker #(.NUM_TREES(1)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_beat_i(beat), .mode_i(mode),
        .alert_out_o(), .alert_oe_n_o(alert_oe_n_o), .irq_o(irq_o),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= {20'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            @(posedge clk_i iff awready) awvalid <= 1'b0;
            @(posedge clk_i iff wready) wvalid <= 1'b0;
        join
        @(posedge clk_i iff bvalid) bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] care, input logic [33:0] exp);
        exp_q.push_back({care, exp});
        @(posedge clk_i);
        araddr <= {20'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk_i iff arready) arvalid <= 1'b0;
        @(posedge clk_i iff rvalid) rready <= 1'b0;
    endtask
    task automatic frame(input logic scb, input logic men, input logic bad);
        logic [31:0] d;
        seed = lfsr(seed);
        d[15:0] = seed;
        seed = lfsr(seed);
        d[31:16] = seed;
        i_ctl.send(d, seed[3:0], scb, men, bad, c);
    endtask
    // Register results appear as read answers, so the oldest note is matched there.
    always @(posedge clk_i) begin
        if (rvalid && rready) begin
            ent = exp_q.pop_front();
            chk({rresp, rdata} & ent[67:34], ent[33:0]);
        end
    end
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`WCRC_OFF_CTRL, ALL, {2'h0, `WCRC_CTRL_RESET});
        rd(`WCRC_OFF_IRQ_MASK, ALL, {2'h0, `WCRC_MASK_RESET});
        rd(12'h010, ALL, {2'h2, 32'h0});
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            if (k == 8) wr(`WCRC_OFF_CTRL, 32'h3);
            mode <= wcrc_mode_t'(k[2:1]);
            repeat (3) @(posedge clk_i);
            frame(k[0], k[2:1] != 0 || k == 8, 1'b0);
            i_ctl.idle();
            repeat (8) @(posedge clk_i);
            rd(`WCRC_OFF_LAST_CRC, LOW, {10'h0, c, 8'h0, c});
        end
        rd(`WCRC_OFF_STATUS, ALL, 34'h0);
        $display("test mapping done");
        wr(`WCRC_OFF_IRQ_MASK, 32'h1);
        frame(1'b0, 1'b1, 1'b0);
        frame(1'b1, 1'b1, 1'b1);
        i_ctl.idle();
        n = 0;
        repeat (20) @(posedge clk_i) n += int'(!alert_oe_n_o);
        chk(34'(n), 34'd6);
        chk({33'h0, irq_o}, 34'h1);
        rd(`WCRC_OFF_LAST_CRC, LOW, {10'h0, c, 8'h0, c ^ 8'h1});
        rd(`WCRC_OFF_STATUS, ALL, 34'h1);
        wr(`WCRC_OFF_STATUS, 32'h1);
        rd(`WCRC_OFF_STATUS, ALL, 34'h0);
        chk({33'h0, irq_o}, 34'h0);
        $display("test error done");
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule
